//--- hw/dfmc_regs.sv
`timescale 1ns/1ns
module dfmc_regs (
  input wire logic clk_in, // 125 MHz control clock
  input wire logic rst_in, // Async reset, active high
  input wire logic wr_en_in, // Write strobe, one cycle
  input wire logic rd_en_in, // Read strobe, one cycle
  input wire logic [6:0] addr_in, // Register address
  input wire logic [7:0] wr_data_in, // Write data
  output logic [7:0] rd_data_out, // Read data, one cycle after
  output dfmc_pkg::dfmc_format_t format_out, // Format controls
  output dfmc_pkg::dfmc_filter_t filter_out, // Filter controls
  output dfmc_pkg::dfmc_mode_one_t mode_one_out, // Path mode controls
  output dfmc_pkg::dfmc_mode_two_t mode_two_out, // Dither/route controls
  output logic [5:0] word_bits_out, // Word length in bits
  output logic frame_invert_out, // Frame clock inverted
  output logic dsp_variant_b_out, // DSP variant B in use
  output logic bit_clock_invert_out, // Bit clocks inverted
  output logic power_down_out, // Device powered down
  output logic filter_bypass_out, // Digital filters bypassed
  input wire logic zero_detect_in, // Raw zero detection
  output logic zero_detect_flag_out, // Zero flag pin
  input wire logic audio_chain_in, // Audio data to forward
  output logic audio_chain_out, // Daisy-chain audio pin
  input wire logic control_chain_in, // Control data to forward
  output logic control_chain_out, // Daisy-chain control pin
  output dfmc_pkg::dfmc_route_t [3:0] route_out // Per-output routing
);

  logic [7:0] format_ff;
  logic [7:0] filter_ff;
  logic [7:0] mode_one_ff;
  logic [7:0] mode_two_ff;
  logic soft_reset;
  dfmc_pkg::dfmc_format_t fmt;
  dfmc_pkg::dfmc_format_t nxt_fmt;
  dfmc_pkg::dfmc_filter_t nxt_filt;
  dfmc_pkg::dfmc_mode_one_t nxt_m1;
  dfmc_pkg::dfmc_mode_two_t nxt_m2;
  logic wr_format;
  logic wr_filter;
  logic wr_mode_one;
  logic wr_mode_two;
  // Bits in one output's routing entry
  localparam int ROUTE_W = $bits(dfmc_pkg::dfmc_route_t);

  // Address match for one write
  function automatic logic hit(input logic [6:0] a,
                               input logic [6:0] r);
    hit = wr_en_in && (a == r);
  endfunction

  // Source and inversion of one output for a routing code
  function automatic dfmc_pkg::dfmc_route_t route_of(
      input logic [1:0] code, input int idx, input logic phase_inv);
    logic right_pin;
    logic neg_pin;
    dfmc_pkg::dfmc_route_t r;
    right_pin = (idx == dfmc_pkg::OUT_RP) || (idx == dfmc_pkg::OUT_RN);
    neg_pin = (idx == dfmc_pkg::OUT_LN) || (idx == dfmc_pkg::OUT_RN);
    case (code)
      dfmc_pkg::ROUTE_STEREO: begin
        r.src_right = right_pin;
        r.invert = neg_pin;
      end
      dfmc_pkg::ROUTE_SWAP: begin
        r.src_right = !right_pin;
        r.invert = neg_pin;
      end
      dfmc_pkg::ROUTE_MONO_LEFT: begin
        r.src_right = 1'b0;
        r.invert = (idx == dfmc_pkg::OUT_LN) ||
                   (idx == dfmc_pkg::OUT_RP);
      end
      dfmc_pkg::ROUTE_MONO_RIGHT: begin
        r.src_right = 1'b1;
        r.invert = (idx == dfmc_pkg::OUT_LP) ||
                   (idx == dfmc_pkg::OUT_RN);
      end
      default: begin
        r.src_right = right_pin;
        r.invert = neg_pin;
      end
    endcase
    r.invert = r.invert ^ phase_inv;
    route_of = r;
  endfunction

  // Word length code to bit count
  function automatic logic [5:0] bits_of(input logic [1:0] code);
    case (code)
      dfmc_pkg::WL_16: bits_of = dfmc_pkg::BITS_16;
      dfmc_pkg::WL_20: bits_of = dfmc_pkg::BITS_20;
      dfmc_pkg::WL_24: bits_of = dfmc_pkg::BITS_24;
      default: bits_of = dfmc_pkg::BITS_32;
    endcase
  endfunction

  // True when the format field selects DSP framing
  function automatic logic is_dsp(input logic [1:0] code);
    is_dsp = (code == dfmc_pkg::FMT_DSP);
  endfunction

  // Any write to the reset address restores every register
  assign soft_reset = hit(addr_in, dfmc_pkg::ADDR_SOFT_RESET);

  // Write strobes for the four stored registers
  assign wr_format = hit(addr_in, dfmc_pkg::ADDR_FORMAT);
  assign wr_filter = hit(addr_in, dfmc_pkg::ADDR_FILTER);
  assign wr_mode_one = hit(addr_in, dfmc_pkg::ADDR_MODE_ONE);
  assign wr_mode_two = hit(addr_in, dfmc_pkg::ADDR_MODE_TWO);

  // Format register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      format_ff <= dfmc_pkg::RST_FORMAT;
    end else if (soft_reset) begin
      format_ff <= dfmc_pkg::RST_FORMAT;
    end else if (wr_format) begin
      format_ff <= wr_data_in;
    end
  end

  // Filter register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      filter_ff <= dfmc_pkg::RST_FILTER;
    end else if (soft_reset) begin
      filter_ff <= dfmc_pkg::RST_FILTER;
    end else if (wr_filter) begin
      filter_ff <= wr_data_in;
    end
  end

  // Mode register one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_one_ff <= dfmc_pkg::RST_MODE_ONE;
    end else if (soft_reset) begin
      mode_one_ff <= dfmc_pkg::RST_MODE_ONE;
    end else if (wr_mode_one) begin
      mode_one_ff <= wr_data_in;
    end
  end

  // Mode register two
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_two_ff <= dfmc_pkg::RST_MODE_TWO;
    end else if (soft_reset) begin
      mode_two_ff <= dfmc_pkg::RST_MODE_TWO;
    end else if (wr_mode_two) begin
      mode_two_ff <= wr_data_in;
    end
  end

  // Next control values, taken combinationally from the stored registers
  assign fmt = dfmc_pkg::dfmc_format_t'(format_ff);
  assign nxt_fmt = fmt;
  assign nxt_filt =
      dfmc_pkg::dfmc_filter_t'(filter_ff);
  assign nxt_m1 =
      dfmc_pkg::dfmc_mode_one_t'(mode_one_ff);
  assign nxt_m2 = dfmc_pkg::dfmc_mode_two_t'(mode_two_ff);

  // Read back of the register file
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= dfmc_pkg::RD_UNMAPPED;
    end else if (soft_reset) begin
      rd_data_out <= dfmc_pkg::RD_UNMAPPED;
    end else if (rd_en_in) begin
      case (addr_in)
        dfmc_pkg::ADDR_FORMAT: rd_data_out <= format_ff;
        dfmc_pkg::ADDR_FILTER: rd_data_out <= filter_ff;
        dfmc_pkg::ADDR_MODE_ONE: rd_data_out <= mode_one_ff;
        dfmc_pkg::ADDR_MODE_TWO: rd_data_out <= mode_two_ff;
        default: rd_data_out <= dfmc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // Field outputs registered from the register file
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      format_out <= dfmc_pkg::dfmc_format_t'(dfmc_pkg::RST_FORMAT);
      filter_out <= dfmc_pkg::dfmc_filter_t'(dfmc_pkg::RST_FILTER);
      mode_one_out <= dfmc_pkg::dfmc_mode_one_t'(dfmc_pkg::RST_MODE_ONE);
      mode_two_out <= dfmc_pkg::dfmc_mode_two_t'(dfmc_pkg::RST_MODE_TWO);
    end else if (soft_reset) begin
      format_out <= dfmc_pkg::dfmc_format_t'(dfmc_pkg::RST_FORMAT);
      filter_out <= dfmc_pkg::dfmc_filter_t'(dfmc_pkg::RST_FILTER);
      mode_one_out <= dfmc_pkg::dfmc_mode_one_t'(dfmc_pkg::RST_MODE_ONE);
      mode_two_out <= dfmc_pkg::dfmc_mode_two_t'(dfmc_pkg::RST_MODE_TWO);
    end else begin
      format_out <= nxt_fmt;
      filter_out <= nxt_filt;
      mode_one_out <= nxt_m1;
      mode_two_out <= nxt_m2;
    end
  end

  // Decoded interface and power controls
  // Frame polarity bit picks the DSP variant under DSP framing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_bits_out <= dfmc_pkg::BITS_24;
      frame_invert_out <= 1'b0;
      dsp_variant_b_out <= 1'b0;
      bit_clock_invert_out <= 1'b0;
      power_down_out <= 1'b0;
      filter_bypass_out <= 1'b0;
    end else if (soft_reset) begin
      word_bits_out <= dfmc_pkg::BITS_24;
      frame_invert_out <= 1'b0;
      dsp_variant_b_out <= 1'b0;
      bit_clock_invert_out <= 1'b0;
      power_down_out <= 1'b0;
      filter_bypass_out <= 1'b0;
    end else begin
      word_bits_out <= bits_of(fmt.word_length_sel);
      frame_invert_out <= fmt.frame_clock_polarity &&
          !is_dsp(fmt.data_format_sel);
      dsp_variant_b_out <= fmt.frame_clock_polarity &&
          is_dsp(fmt.data_format_sel);
      bit_clock_invert_out <= fmt.bit_clock_polarity;
      power_down_out <= fmt.power_down_sel;
      filter_bypass_out <= nxt_m1.filter_bypass_rate_mode;
    end
  end

  // Zero flag pin with forced-high override
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      zero_detect_flag_out <= 1'b0;
    end else if (soft_reset) begin
      zero_detect_flag_out <= 1'b0;
    end else begin
      zero_detect_flag_out <= nxt_filt.zero_flag_force_high ||
                              zero_detect_in;
    end
  end

  // Daisy-chain forwarding, held low when disabled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      audio_chain_out <= 1'b0;
      control_chain_out <= 1'b0;
    end else if (soft_reset) begin
      audio_chain_out <= 1'b0;
      control_chain_out <= 1'b0;
    end else begin
      audio_chain_out <= nxt_m2.audio_chain_out_en &&
                         audio_chain_in;
      control_chain_out <= nxt_m2.control_chain_out_en &&
                           control_chain_in;
    end
  end

  // Per-output routing, one flop pair each
  // Stereo reset leaves only the negative pins inverted
  genvar g;
  generate
    for (g = 0; g < dfmc_pkg::NUM_OUTS; g++) begin : g_route
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          route_out[g] <= dfmc_pkg::dfmc_route_t'(
              dfmc_pkg::RST_ROUTE[g*ROUTE_W +: ROUTE_W]);
        end else if (soft_reset) begin
          route_out[g] <= dfmc_pkg::dfmc_route_t'(
              dfmc_pkg::RST_ROUTE[g*ROUTE_W +: ROUTE_W]);
        end else begin
          route_out[g] <= route_of(nxt_m2.channel_routing_sel, g,
                                   fmt.output_phase_invert);
        end
      end
    end
  endgenerate

endmodule // dfmc_regs

//--- hw/dfmc_pkg.sv
package dfmc_pkg;

  // Register addresses on the control port
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] ADDR_FORMAT = 7'h05;
  localparam logic [6:0] ADDR_FILTER = 7'h06;
  localparam logic [6:0] ADDR_MODE_ONE = 7'h07;
  localparam logic [6:0] ADDR_MODE_TWO = 7'h08;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h09;

  // Reset values
  localparam logic [7:0] RST_FORMAT = 8'h0A;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_MODE_ONE = 8'h00;
  localparam logic [7:0] RST_MODE_TWO = 8'h02;
  localparam logic [7:0] RST_ROUTE = 8'hE4;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field codes
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] WL_32 = 2'h3;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_20 = 6'h14;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] BITS_32 = 6'h20;
  localparam logic [1:0] FMT_DSP = 2'h3;
  localparam logic [1:0] ROUTE_STEREO = 2'h0;
  localparam logic [1:0] ROUTE_MONO_LEFT = 2'h1;
  localparam logic [1:0] ROUTE_SWAP = 2'h2;
  localparam logic [1:0] ROUTE_MONO_RIGHT = 2'h3;

  // Analogue output indices
  localparam int OUT_LP = 0;
  localparam int OUT_LN = 1;
  localparam int OUT_RP = 2;
  localparam int OUT_RN = 3;
  localparam int NUM_OUTS = 4;

  typedef struct packed {
    logic power_down_sel;
    logic output_phase_invert;
    logic bit_clock_polarity;
    logic frame_clock_polarity;
    logic [1:0] data_format_sel;
    logic [1:0] word_length_sel;
  } dfmc_format_t;

  typedef struct packed {
    logic zero_flag_force_high;
    logic [1:0] deemphasis_sel;
    logic [1:0] bitstream_comp_filter;
    logic [2:0] pcm_filter_response;
  } dfmc_filter_t;

  typedef struct packed {
    logic filter_bypass_rate_mode;
    logic [1:0] rate_band_sel;
    logic [2:0] clock_ratio_sel;
    logic [1:0] path_mode_sel;
  } dfmc_mode_one_t;

  typedef struct packed {
    logic reserved;
    logic plus_path_gain;
    logic control_chain_out_en;
    logic audio_chain_out_en;
    logic [1:0] channel_routing_sel;
    logic [1:0] dither_sel;
  } dfmc_mode_two_t;

  // Per analogue output: source channel and inversion
  typedef struct packed {
    logic src_right;
    logic invert;
  } dfmc_route_t;

endpackage

//--- tb/dfmc_asserts.sv
`timescale 1ns/1ns
module dfmc_asserts (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic wr_en_in, // Write
  input wire logic [6:0] addr_in, // Address
  input wire logic [7:0] wr_data_in, // Data
  input wire dfmc_pkg::dfmc_format_t format_out, // Format
  input wire dfmc_pkg::dfmc_filter_t filter_out, // Filter
  input wire dfmc_pkg::dfmc_mode_one_t mode_one_out, // Mode one
  input wire dfmc_pkg::dfmc_mode_two_t mode_two_out, // Mode two
  input wire logic [5:0] word_bits_out, // Bits
  input wire logic zero_detect_in, // Raw zero
  input wire logic zero_detect_flag_out, // Flag
  input wire logic audio_chain_in, // Chain in
  input wire logic audio_chain_out, // Chain out
  input wire dfmc_pkg::dfmc_route_t [3:0] route_out // Routing
);
  localparam logic [7:0] RT [4] = '{8'hE4, 8'h14, 8'h4E, 8'hEB};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Writes reach the field outputs two edges on
  property p_fmt;
    wr_en_in && addr_in == 7'h05 |->
      ##2 format_out == $past(wr_data_in, 2);
  endproperty
  property p_flt;
    wr_en_in && addr_in == 7'h06 |-> ##2 filter_out == $past(wr_data_in, 2);
  endproperty
  property p_m1;
    wr_en_in && addr_in == 7'h07 |-> ##2 mode_one_out == $past(wr_data_in, 2);
  endproperty
  property p_m2;
    wr_en_in && addr_in == 7'h08 |-> ##2 mode_two_out == $past(wr_data_in, 2);
  endproperty
  property p_swrst;
    wr_en_in && addr_in == 7'h09 |->
      ##2 {format_out, filter_out, mode_one_out, mode_two_out} ==
        32'h0A000002;
  endproperty
  // Decodes track the stored fields
  property p_bits;
    word_bits_out == (format_out.word_length_sel == 2'h3 ? 6'h20 :
      6'h10 + {2'h0, format_out.word_length_sel, 2'h0});
  endproperty
  property p_zero_detect_flag;
    filter_out.zero_flag_force_high [*2] |-> zero_detect_flag_out;
  endproperty
  property p_chain;
    mode_two_out.audio_chain_out_en [*2] |->
      audio_chain_out == $past(audio_chain_in);
  endproperty
  property p_route;
    ($stable(mode_two_out) && $stable(format_out)) [*2] |->
      8'(route_out) == (RT[mode_two_out.channel_routing_sel]
      ^ {4{1'b0, format_out.output_phase_invert}});
  endproperty
  a_fmt: assert property (p_fmt) else $error("format update");
  a_flt: assert property (p_flt) else $error("filter update");
  a_m1: assert property (p_m1) else $error("mode one update");
  a_m2: assert property (p_m2) else $error("mode two update");
  a_swrst: assert property (p_swrst) else $error("soft reset");
  a_bits: assert property (p_bits) else $error("word bits");
  a_zero_detect_flag: assert property (p_zero_detect_flag) else $error("zero force");
  a_chain: assert property (p_chain) else $error("audio chain");
  a_route: assert property (p_route) else $error("route");
  c_swrst: cover property (wr_en_in && addr_in == 7'h09);
  c_right: cover property (mode_two_out.channel_routing_sel == 2'h3);
  c_force: cover property (filter_out.zero_flag_force_high && !zero_detect_in);
endmodule // dfmc_asserts
bind dfmc_regs dfmc_asserts dfmc_asserts_i (.clk_in, .rst_in, .wr_en_in,
  .addr_in, .wr_data_in, .format_out, .filter_out, .mode_one_out,
  .mode_two_out, .word_bits_out, .zero_detect_in, .zero_detect_flag_out,
  .audio_chain_in, .audio_chain_out, .route_out);

//--- tb/dfmc_host.sv
`timescale 1ns/1ns
module dfmc_host (
  input wire logic clk_in, // Bus clock
  output logic wr_en_out, // Write strobe
  output logic rd_en_out, // Read strobe
  output logic [6:0] addr_out, // Address
  output logic [7:0] data_out // Write data
);
  // Idle bus at time zero
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 7'h00;
    data_out = 8'h00;
  end
  // One access; idle lines scrambled so stale values never match
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    wr_en_out = w;
    rd_en_out = !w;
    addr_out = a;
    data_out = d;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = ~a;
    data_out = ~d;
  endtask
endmodule // dfmc_host

//--- tb/tb_dfmc_regs.sv
`timescale 1ns/1ns
module tb_dfmc_regs;
  localparam logic [7:0] RT [4] = '{8'hE4, 8'h14, 8'h4E, 8'hEB};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr, rd, zd = 1'b0, ac = 1'b0, cc = 1'b0, rdq = 1'b0, en;
  logic [6:0] ad, a;
  logic [7:0] wd, rdo, d, fo, fl, m1, m2, ro, rm [5:8], q [$];
  logic [5:0] wb;
  logic fi, dv, bi, pd, fb, zf, ao, co;
  int fails = 0;
  int cmp_count = 0;
  integer seed = 32'hCDFFE4E6;
  dfmc_host dfmc_host_i (.clk_in, .wr_en_out(wr), .rd_en_out(rd),
    .addr_out(ad), .data_out(wd));
  dfmc_regs dfmc_regs_i (.clk_in, .rst_in, .wr_en_in(wr), .rd_en_in(rd),
    .addr_in(ad), .wr_data_in(wd), .rd_data_out(rdo), .format_out(fo),
    .filter_out(fl), .mode_one_out(m1), .mode_two_out(m2),
    .word_bits_out(wb), .frame_invert_out(fi), .dsp_variant_b_out(dv),
    .bit_clock_invert_out(bi), .power_down_out(pd), .filter_bypass_out(fb),
    .zero_detect_in(zd), .zero_detect_flag_out(zf), .audio_chain_in(ac),
    .audio_chain_out(ao), .control_chain_in(cc), .control_chain_out(co),
    .route_out(ro));
  // Clock
  always #4 clk_in = ~clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Compares %0d, fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Read answers: oldest note compared on each answer
  always @(posedge clk_in) rdq <= rd && !rst_in;
  always @(negedge clk_in) if (rdq) chk(rdo, q.pop_front());
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    dfmc_host_i.acc(1'b1, a, d);
    // Decoded outputs follow one edge after the register
    @(posedge clk_in);
    #1;
    if (a inside {[7'h05:7'h08]}) rm[a] = d;
    if (a == 7'h09) rm = '{8'h0A, 8'h00, 8'h00, 8'h02};
  endtask
  task automatic rd_reg(input logic [6:0] a);
    q.push_back(a inside {[7'h05:7'h08]} ? rm[a] : 8'h00);
    dfmc_host_i.acc(1'b0, a, 8'h00);
  endtask
  // Main sequence
  initial begin
    rm = '{8'h0A, 8'h00, 8'h00, 8'h02};
    repeat (8) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk({wb, pd, fb, ro}, {6'h18, 2'h0, 8'hE4});
    for (int i = 4; i < 11; i++) rd_reg(7'(i));
    // Every word length and format, random upper bits
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      d[3:0] = 4'(i);
      wr_reg(7'h05, d);
      chk({wb, fi, dv, bi, pd}, {(d[1:0] == 2'h3 ? 6'h20 : 6'h10 +
        {2'h0, d[1:0], 2'h0}), d[4] & ~&d[3:2], d[4] & &d[3:2], d[5],
        d[7]});
      rd_reg(7'h05);
    end
    // Random legal codes in the other registers
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      a = 7'h06 + 7'(i % 3);
      if (a == 7'h06) d = d & ~{5'h00, d[2:0] > 3'h4, 2'h0};
      if (a == 7'h07) d = d & ~{1'b0, &d[6:5], 1'b0, &d[4:2], 2'h0,
        &d[1:0], 1'b0};
      if (a == 7'h08) d[7] = 1'b0;
      wr_reg(a, d);
      rd_reg(a);
      chk(fb, rm[7][7]);
    end
    // Each routing code with and without phase inversion
    for (int i = 0; i < 8; i++) begin
      wr_reg(7'h05, {1'b0, i[2], 6'h0A});
      wr_reg(7'h08, {4'h0, 2'(i), 2'h2});
      chk(ro, RT[i[1:0]] ^ (i[2] ? 8'h55 : 8'h00));
    end
    // Chain forwarding enabled then off, zero flag forcing off then on
    for (int e = 0; e < 2; e++) begin
      en = e[0];
      wr_reg(7'h08, en ? 8'h02 : 8'h32);
      wr_reg(7'h06, {en, 7'h00});
      for (int i = 0; i < 6; i++) begin
        d = 8'($random(seed));
        {ac, cc, zd} = d[2:0];
        @(posedge clk_in);
        #1;
        chk({ao, co, zf}, {d[2:1] & {2{~en}}, d[0] | en});
      end
    end
    wr_reg(7'h0B, 8'hFF);
    for (int i = 5; i < 9; i++) rd_reg(7'(i));
    wr_reg(7'h09, 8'h5A);
    for (int i = 5; i < 9; i++) rd_reg(7'(i));
    repeat (3) @(posedge clk_in);
    results();
  end
  // Watchdog
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // tb_dfmc_regs
